// file: rtl/sli_pkg.sv
// Package: constants and carrier types of the LED/reset block
//--------------------
// Operation
// (R01) Button held over 4.5 s restarts hardware
// (R02) Restart start: failure LED only lit
// (R03) Then power LED back on before lamp test
// (R04) After any start all LEDs lit 2.5 s
// (R05) Power LED skips lamp test, shows status
// (R06) Power LED steady on when supplied, ready
// (R07) Run LED: on normal, flash boot, off problem
// (R08) Failure LED on/flash on critical fault
// (R09) Bus activity: on listen, flash master, off error
// (R10) Bus error LED on for bus faults
// (R11) Operation port: on cable, flash traffic
// (R12) Service port likewise, off if DHCP refused
// (R13) Socket LEDs: speed yellow, link/activity green
// (R14) LED meaning follows class 1/2 master mode
// (R15) Debounced button, one common flash rate
//--------------------
package sli_pkg;

   // --------------------
   // Timing
   // --------------------
   localparam int unsigned CLK_HZ        = 50_000_000; // System clock rate
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned LONG_PRESS_MS = 4500;  // Press that restarts
   localparam int unsigned LAMP_MS       = 2500;  // All-LED lamp test
   localparam int unsigned RESTART_MS    = 60000; // Whole restart duration
   localparam int unsigned POWER_PH_MS   = 500;   // Failure plus power step
   localparam int unsigned FAIL_PH_MS    = RESTART_MS - LAMP_MS - POWER_PH_MS;
   localparam int unsigned DEBOUNCE_MS   = 20;    // Button settle time
   localparam int unsigned FLASH_MS      = 250;   // Half period of flashing
   localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
   localparam int unsigned LAMP_CYC       = LAMP_MS * CYC_PER_MS;
   localparam int unsigned POWER_PH_CYC   = POWER_PH_MS * CYC_PER_MS;
   localparam int unsigned FAIL_PH_CYC    = FAIL_PH_MS * CYC_PER_MS;
   localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned FLASH_CYC      = FLASH_MS * CYC_PER_MS;

   // --------------------
   // Register map (byte addresses)
   // --------------------
   localparam logic [7:0] REG_CTRL  = 8'h00; // Bit 0: class 1 master mode
   localparam logic [7:0] REG_EVENT = 8'h04; // Sticky events, read clears
   localparam logic [7:0] REG_MASK  = 8'h08; // Interrupt mask
   localparam logic [7:0] REG_STATE = 8'h0c; // Phase and button state
   localparam int unsigned EV_W     = 3;
   localparam int unsigned EV_PRESS = 0;     // Long press accepted
   localparam int unsigned EV_LAMP  = 1;     // Lamp test finished
   localparam int unsigned EV_BTN   = 2;     // Debounced button pressed
   localparam logic [EV_W-1:0] MASK_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Indication phases
   typedef enum logic [1:0] {
      PH_FAIL, PH_POWER, PH_LAMP, PH_NORMAL
   } sli_phase_t;

   // Status from CPU, bus controller and network ports
   typedef struct packed {
      logic       ready;       // Supplied and ready
      logic       booting;     // System still booting
      logic       problem;     // Operating problem
      logic       critical;    // CPU critical fault or memory defect
      logic       crit_flash;  // Show critical fault as flashing
      logic       fb_listen;   // Passive bus listening
      logic       fb_master;   // Active bus access as master
      logic       fb_conn_err; // Connection or communication error
      logic       fb_perm_err; // Permanent bus error
      logic       fb_no_bus;   // Bus not connected
      logic       fb_no_comm;  // No communication
      logic       op_cable;    // Operation port cable present
      logic       op_traffic;  // Operation port messages
      logic       sv_cable;    // Service port cable present
      logic       sv_traffic;  // Service port messages
      logic       sv_dhcp_ok;  // PC accepted offered address
      logic [1:0] sk_link;     // Socket link up
      logic [1:0] sk_act;      // Socket activity
      logic [1:0] sk_fast;     // Socket at 100 Mbit/s
   } sli_status_t;

   // Front-panel and socket LEDs, high lights the LED
   typedef struct packed {
      logic       power;
      logic       run;
      logic       failure;
      logic       fieldbus_activity_led;
      logic       fieldbus_error_led;
      logic       operation_port;
      logic       service_port;
      logic [1:0] sk_speed;
      logic [1:0] sk_link;
   } sli_leds_t;

endpackage : sli_pkg

// file: rtl/sli_top.sv
// Module: front-panel LED indication, lamp test and button restart logic
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module sli_top
   import sli_pkg::*;
#(
   parameter int unsigned LONG_PRESS_CYCLES = LONG_PRESS_CYC,
   parameter int unsigned LAMP_CYCLES       = LAMP_CYC,
   parameter int unsigned POWER_PH_CYCLES   = POWER_PH_CYC,
   parameter int unsigned FAIL_PH_CYCLES    = FAIL_PH_CYC,
   parameter int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_CYC,
   parameter int unsigned FLASH_CYCLES      = FLASH_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Panel and system
   input  wire logic        btn_n,
   input  sli_status_t      status,
   output sli_leds_t        leds,
   output logic             hw_restart,
   output logic             irq
);

   // --------------------
   // Declarations
   // --------------------
   logic [1:0]    btn_sync_ff;   // Button synchroniser
   logic          btn_ff;        // Debounced level, high = pressed
   logic [31:0]   deb_cnt_ff;    // Settle counter
   logic [31:0]   press_cnt_ff;  // Held time counter
   logic          fired_ff;      // Restart taken for this press
   logic          long_press;    // One-cycle long press event
   sli_phase_t    phase_ff;      // Indication phase
   logic [31:0]   ph_cnt_ff;     // Phase timer
   logic          lamp_done;     // Lamp test end event
   logic [31:0]   fl_cnt_ff;     // Flash divider
   logic          blink_ff;      // Common flash waveform
   logic          class1_ff;     // Class 1 master mode
   logic [EV_W-1:0] ev_ff;       // Sticky events
   logic [EV_W-1:0] mask_ff;     // Interrupt mask
   logic [EV_W-1:0] ev_set;      // Events this cycle
   logic          aw_ok_ff;      // Write address held
   logic          w_ok_ff;       // Write data held
   logic [7:0]    awaddr_ff;
   logic [31:0]   wdata_ff;
   logic [3:0]    wstrb_ff;
   logic          wr_go;         // Both halves of a write present
   logic          rd_go;         // Read address taken
   logic          ev_rd_clr;     // Event register read
   logic          btn_edge;      // Debounced press start
   sli_leds_t     nxt_leds;      // Normal indication

   // --------------------
   // Button synchronise and debounce
   // --------------------
   // Two flops against metastability; only the second is looked at
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         btn_sync_ff <= 2'h0;
      end else begin
         btn_sync_ff <= {btn_sync_ff[0], ~btn_n};               // [R15]
      end
   end

   // Level accepted only after it stayed different for the settle time
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         btn_ff     <= 1'b0;
         deb_cnt_ff <= 32'h0;
      end else if (btn_sync_ff[1] == btn_ff) begin
         deb_cnt_ff <= 32'h0;                                   // Stable
      end else if (deb_cnt_ff >= DEBOUNCE_CYCLES - 1) begin
         btn_ff     <= btn_sync_ff[1];                          // [R15]
         deb_cnt_ff <= 32'h0;
      end else begin
         deb_cnt_ff <= deb_cnt_ff + 32'h1;
      end
   end

   // Held time; strictly longer than the threshold fires once per press
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         press_cnt_ff <= 32'h0;
         fired_ff     <= 1'b0;
      end else if (!btn_ff) begin
         press_cnt_ff <= 32'h0;
         fired_ff     <= 1'b0;
      end else begin
         if (press_cnt_ff <= LONG_PRESS_CYCLES) begin
            press_cnt_ff <= press_cnt_ff + 32'h1;
         end
         if (long_press) begin
            fired_ff <= 1'b1;
         end
      end
   end

   // Count has passed the threshold by one cycle: held over 4.5 s
   assign long_press = btn_ff && !fired_ff
                       && (press_cnt_ff == LONG_PRESS_CYCLES);  // [R01]
   assign btn_edge   = btn_sync_ff[1] && !btn_ff
                       && (deb_cnt_ff >= DEBOUNCE_CYCLES - 1);

   // --------------------
   // Phase sequencer
   // --------------------
   // Reset enters the lamp test directly; a long press runs the full
   // restart first. A long press during a restart starts it over.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phase_ff  <= PH_LAMP;                                  // [R04]
         ph_cnt_ff <= 32'h0;
      end else if (long_press) begin
         phase_ff  <= PH_FAIL;                                  // [R01]
         ph_cnt_ff <= 32'h0;
      end else begin
         ph_cnt_ff <= ph_cnt_ff + 32'h1;
         unique case (phase_ff)
            PH_FAIL: begin
               if (ph_cnt_ff >= FAIL_PH_CYCLES - 1) begin
                  phase_ff  <= PH_POWER;                        // [R03]
                  ph_cnt_ff <= 32'h0;
               end
            end
            PH_POWER: begin
               if (ph_cnt_ff >= POWER_PH_CYCLES - 1) begin
                  phase_ff  <= PH_LAMP;                         // [R03]
                  ph_cnt_ff <= 32'h0;
               end
            end
            PH_LAMP: begin
               if (lamp_done) begin
                  phase_ff  <= PH_NORMAL;                       // [R04]
                  ph_cnt_ff <= 32'h0;
               end
            end
            PH_NORMAL: begin
               ph_cnt_ff <= 32'h0;                              // Idle
            end
         endcase
      end
   end

   assign lamp_done = (phase_ff == PH_LAMP)
                      && (ph_cnt_ff >= LAMP_CYCLES - 1);

   // --------------------
   // Common flash rate
   // --------------------
   // One divider for all LEDs keeps flashing LEDs in step
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fl_cnt_ff <= 32'h0;
         blink_ff  <= 1'b0;
      end else if (fl_cnt_ff >= FLASH_CYCLES - 1) begin
         fl_cnt_ff <= 32'h0;
         blink_ff  <= ~blink_ff;                                // [R15]
      end else begin
         fl_cnt_ff <= fl_cnt_ff + 32'h1;
      end
   end

   // --------------------
   // Normal indication
   // --------------------
   always_comb begin
      nxt_leds = '0;
      nxt_leds.power = status.ready;                            // [R06]
      // Problem beats boot, boot beats normal run
      if (status.problem) begin
         nxt_leds.run = 1'b0;                                   // [R07]
      end else if (status.booting) begin
         nxt_leds.run = blink_ff;                               // [R07]
      end else begin
         nxt_leds.run = 1'b1;                                   // [R07]
      end
      nxt_leds.failure = status.critical
                         && (!status.crit_flash || blink_ff);   // [R08]
      // Class 1 owns the bus cyclically, so there is no passive state:
      // bus activity then flashes whenever the link is healthy
      if (status.fb_conn_err) begin
         nxt_leds.fieldbus_activity_led = 1'b0;                 // [R09]
      end else if (status.fb_master || class1_ff) begin
         nxt_leds.fieldbus_activity_led = blink_ff;             // [R09] [R14]
      end else begin
         nxt_leds.fieldbus_activity_led = status.fb_listen;     // [R09]
      end
      nxt_leds.fieldbus_error_led = status.fb_perm_err
                                    || status.fb_no_bus
                                    || status.fb_no_comm;       // [R10]
      nxt_leds.operation_port = status.op_cable
                                && (!status.op_traffic || blink_ff); // [R11]
      nxt_leds.service_port = status.sv_cable && status.sv_dhcp_ok
                              && (!status.sv_traffic || blink_ff); // [R12]
      nxt_leds.sk_speed = status.sk_link & status.sk_fast;      // [R13]
      nxt_leds.sk_link  = status.sk_link
                          & ~(status.sk_act & {2{blink_ff}});   // [R13]
   end

   // Registered outputs per phase
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         leds       <= '0;
         hw_restart <= 1'b0;
      end else begin
         hw_restart <= (phase_ff == PH_FAIL);                   // [R01]
         unique case (phase_ff)
            PH_FAIL: begin
               leds         <= '0;
               leds.failure <= 1'b1;                            // [R02]
            end
            PH_POWER: begin
               leds         <= '0;
               leds.failure <= 1'b1;
               leds.power   <= 1'b1;                            // [R03]
            end
            PH_LAMP: begin
               leds       <= '1;                                // [R04]
               leds.power <= nxt_leds.power;                    // [R05]
            end
            PH_NORMAL: begin
               leds <= nxt_leds;
            end
         endcase
      end
   end

   // --------------------
   // AXI4-Lite write channel
   // --------------------
   assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_ok_ff && !s_axi_bvalid;
   assign wr_go         = aw_ok_ff && w_ok_ff;

   // Address and data may come in either order
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_ok_ff  <= 1'b0;
         w_ok_ff   <= 1'b0;
         awaddr_ff <= 8'h0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_ff  <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff  <= 1'b0;
         end
      end
   end

   // Register update and write response
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         class1_ff    <= 1'b0;
         mask_ff      <= MASK_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            unique case (awaddr_ff[7:2])
               REG_CTRL[7:2]: begin
                  if (wstrb_ff[0]) begin
                     class1_ff <= wdata_ff[0];                  // [R14]
                  end
               end
               REG_MASK[7:2]: begin
                  if (wstrb_ff[0]) begin
                     mask_ff <= wdata_ff[EV_W-1:0];
                  end
               end
               REG_EVENT[7:2], REG_STATE[7:2]: begin
                  s_axi_bresp <= RESP_OKAY;                     // Read only
               end
               default: begin
                  s_axi_bresp <= RESP_SLVERR;                   // Unmapped
               end
            endcase
         end
      end
   end

   // --------------------
   // AXI4-Lite read channel
   // --------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go         = s_axi_arvalid && s_axi_arready;
   assign ev_rd_clr     = rd_go && (s_axi_araddr[7:2] == REG_EVENT[7:2]);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0;
            unique case (s_axi_araddr[7:2])
               REG_CTRL[7:2]:  s_axi_rdata[0] <= class1_ff;
               REG_EVENT[7:2]: s_axi_rdata[EV_W-1:0] <= ev_ff;
               REG_MASK[7:2]:  s_axi_rdata[EV_W-1:0] <= mask_ff;
               REG_STATE[7:2]: s_axi_rdata[3:0] <= {hw_restart, btn_ff,
                                                    phase_ff};
               default:        s_axi_rresp <= RESP_SLVERR;
            endcase
         end
      end
   end

   // --------------------
   // Events and interrupt
   // --------------------
   assign ev_set = {btn_edge, lamp_done, long_press};

   // Read clears, but an event in the same cycle survives the clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ev_ff <= '0;
      end else begin
         ev_ff <= (ev_rd_clr ? '0 : ev_ff) | ev_set;
      end
   end

   assign irq = |(ev_ff & mask_ff);

endmodule : sli_top

// file: tb/sli_top_properties.sv
// Checker: timing properties of the LED and restart block
`timescale 1ns/1ps
module sli_top_properties
   import sli_pkg::*;
#(
   parameter int unsigned LONG_PRESS_CYCLES = LONG_PRESS_CYC,
   parameter int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_CYC,
   parameter int unsigned FAIL_PH_CYCLES    = FAIL_PH_CYC
) (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        btn_n,
   input wire sli_status_t status,
   input wire sli_leds_t   leds,
   input wire logic        hw_restart,
   input wire logic        irq
);
   // --------------------
   // Helper counters and properties
   // --------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   int unsigned fail_cnt_ff; // Cycles spent in the failure phase
   int unsigned held_ff;     // Raw cycles the button is held
   // Failure phase length, cleared whenever the phase is left
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !hw_restart) fail_cnt_ff <= 0;
      else fail_cnt_ff <= fail_cnt_ff + 1;
   end
   // Raw press length; sync and debounce add to it, so loose bound
   always_ff @(posedge clk_sys) begin
      if (!rst_n || btn_n) held_ff <= 0;
      else held_ff <= held_ff + 1;
   end
   property p_fail_only; hw_restart |-> leds == 11'h100; endproperty
   a_fail_only: assert property (p_fail_only) else $error("fail leds");
   property p_fail_len; $fell(hw_restart) |-> fail_cnt_ff == FAIL_PH_CYCLES;
   endproperty
   a_fail_len: assert property (p_fail_len) else $error("fail length");
   property p_press; $rose(hw_restart) |->
      held_ff >= LONG_PRESS_CYCLES + DEBOUNCE_CYCLES; endproperty
   a_press: assert property (p_press) else $error("early restart");
   property p_power_back; $fell(hw_restart) |-> leds == 11'h500; endproperty
   a_power_back: assert property (p_power_back) else $error("pwr");
   property p_lamp; $fell(hw_restart) |-> ##[4:6] leds[9:0] == 10'h3ff;
   endproperty
   a_lamp: assert property (p_lamp) else $error("no lamp test");
   // Run lit means lamp or normal: power shows supply state there
   property p_power_lvl; leds.run |-> leds.power == $past(status.ready);
   endproperty
   a_power_lvl: assert property (p_power_lvl) else $error("pwr lvl");
   property p_fb_err; leds.power && !leds.failure && !leds.fieldbus_error_led
      |-> !($past(status.fb_perm_err) || $past(status.fb_no_bus)
      || $past(status.fb_no_comm)); endproperty
   a_fb_err: assert property (p_fb_err) else $error("bus err led");
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("bvalid stuck");
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_done: assert property (p_r_done) else $error("rvalid stuck");
   c_restart: cover property ($rose(hw_restart));
   c_irq: cover property ($rose(irq));
   c_flash: cover property ($fell(leds.run) && leds.power);
endmodule : sli_top_properties
bind sli_top sli_top_properties #(.LONG_PRESS_CYCLES(LONG_PRESS_CYCLES),
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .FAIL_PH_CYCLES(FAIL_PH_CYCLES))
   sli_top_properties_inst (.clk_sys, .rst_n, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready, .btn_n, .status, .leds, .hw_restart, .irq);

// file: tb/sli_operator.sv
// Operator model: presses the front-panel reset button
`timescale 1ns/1ps
module sli_operator (
   input wire logic clk_sys,
   output logic     btn_n
);
   // Released button rests high on its pull-up
   initial btn_n = 1'b1;
   // Hold the button for a number of clock cycles
   task automatic press(input int unsigned cyc);
      @(posedge clk_sys);
      btn_n <= 1'b0;
      repeat (cyc) @(posedge clk_sys);
      btn_n <= 1'b1;
   endtask : press
endmodule : sli_operator

// file: tb/sli_top_tb_top.sv
// Testbench: lamp test, LED status, registers and restart
`timescale 1ns/1ps
module sli_top_tb_top;
   import sli_pkg::*;
   logic        clk_sys, rst_n, btn_n, hw_restart, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   sli_status_t status, st;
   sli_leds_t   leds;
   int          failures, compares, n;
   logic [34:0] note;       // Oldest note: {check data, resp, data}
   logic [34:0] note_q[$];  // Expected bus answers in order
   // Short counts keep the run brief
   sli_top #(.LONG_PRESS_CYCLES(40), .LAMP_CYCLES(20), .POWER_PH_CYCLES(5),
      .FAIL_PH_CYCLES(30), .DEBOUNCE_CYCLES(4), .FLASH_CYCLES(3))
      sli_top_inst (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .btn_n, .status, .leds,
      .hw_restart, .irq);
   sli_operator sli_operator_inst (.clk_sys, .btn_n);
   // 50 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // --------------------
   // Shared tasks
   // --------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   // Random status that flashes no LED: flash bits masked off
   function automatic sli_status_t rand_steady();
      return sli_status_t'($urandom & ~32'h12828c);
   endfunction : rand_steady
   // Normal indication for a steady status, class 2 mode
   function automatic sli_leds_t exp_leds(sli_status_t s);
      sli_leds_t e;
      e.power = s.ready;
      e.run = !s.problem;
      e.failure = s.critical;
      e.fieldbus_activity_led = s.fb_listen & !s.fb_conn_err;
      e.fieldbus_error_led = s.fb_perm_err | s.fb_no_bus | s.fb_no_comm;
      e.operation_port = s.op_cable;
      e.service_port = s.sv_cable & s.sv_dhcp_ok;
      e.sk_speed = s.sk_link & s.sk_fast;
      e.sk_link = s.sk_link;
      return e;
   endfunction : exp_leds
   // Bus write: both halves offered at once, held until taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      @(posedge clk_sys);
      note_q.push_back({1'b0, r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'($urandom | 1);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   // Bus read; data checked on OKAY
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      @(posedge clk_sys);
      note_q.push_back({r == RESP_OKAY, r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // Answers meet the oldest note
   always @(posedge clk_sys) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      begin
         note = note_q.pop_front();
         check(s_axi_bvalid ? s_axi_bresp : s_axi_rresp, note[33:32]);
         if (note[34]) check(s_axi_rdata, note[31:0]);
      end
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      conclude();
   end
   // --------------------
   // Scenarios
   // --------------------
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
      {s_axi_wdata, s_axi_wstrb} = 36'h1_0000_0000;
      status = '0;
      void'($urandom(32'h3641));
      repeat (12) @(posedge clk_sys);
      status <= rand_steady();
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check(leds, {status.ready, 10'h3ff});
      repeat (30) @(posedge clk_sys);
      repeat (8) begin
         status <= rand_steady();
         repeat (3) @(posedge clk_sys);
         check(leds, exp_leds(status));
      end
      axi_rd(REG_EVENT, 32'h2, RESP_OKAY);
      axi_rd(REG_EVENT, 32'h0, RESP_OKAY);
      axi_wr(REG_MASK, 32'h7, RESP_OKAY);
      axi_rd(REG_MASK, 32'h7, RESP_OKAY);
      axi_wr(8'h10, 32'h1, RESP_SLVERR);
      axi_rd(8'h10, 32'h0, RESP_SLVERR);
      axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
      axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
      // Boot, traffic and class 1 access all flash together
      st = rand_steady();
      {st.problem, st.booting, st.fb_conn_err} = 3'b010;
      {st.op_cable, st.op_traffic} = 2'b11;
      status <= st;
      repeat (3) @(posedge clk_sys);
      n = 0;
      note[2] = leds.run;
      repeat (12) begin
         @(posedge clk_sys);
         n += (leds.run != note[2]);
         check(leds.fieldbus_activity_led, leds.run);
         check(leds.operation_port, leds.run);
         note[2] = leds.run;
      end
      check(n > 1, 1'b1);
      axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
      status <= rand_steady();
      // A bounce-length press must leave no trace
      sli_operator_inst.press(2);
      repeat (20) @(posedge clk_sys);
      check(hw_restart, 1'b0);
      check(irq, 1'b0);
      axi_wr(REG_MASK, 32'h1, RESP_OKAY);
      fork
         sli_operator_inst.press(70);
      join_none
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!hw_restart && n < 200);
      check(leds, 11'h100);
      check(irq, 1'b1);
      axi_rd(REG_EVENT, 32'h5, RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b0);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hw_restart && n < 200);
      check(leds, 11'h500);
      repeat (7) @(posedge clk_sys);
      check(leds[9:0], 10'h3ff);
      repeat (30) @(posedge clk_sys);
      check(leds, exp_leds(status));
      conclude();
   end
endmodule : sli_top_tb_top
